// ### bus_driver_pkg.sv
// Constants shared by the 18-lane latchable bus driver.
// Assumes a single 10 MHz system clock; the lane clock pin is sampled on it.
package bus_driver_pkg;
    localparam int   LANES        = 18;
    localparam int   OTHER_LANES  = 17;
    localparam logic CLK_PREV_RST = 1'b1;
    localparam real  MCLK_NS      = 100.0;
endpackage : bus_driver_pkg

// ### bus_lane.sv
// One data lane: storage element plus output select.
// Assumes capture pulse is already qualified by the caller.
`timescale 1ns/100ps
`default_nettype none
module bus_lane (
    input  wire logic i_mclk,
    input  wire logic i_data,
    input  wire logic i_pass_through_n,
    input  wire logic i_capture,
    output logic      o_stored,
    output logic      o_data
);
    logic store_ff;

    // Storage has no reset
    always_ff @(posedge i_mclk) begin
        if (!i_pass_through_n || i_capture) begin
            store_ff <= i_data;
        end
    end

    assign o_stored = store_ff;
    // Transparent path bypasses the storage
    assign o_data   = i_pass_through_n ? store_ff : i_data;
endmodule : bus_lane
`default_nettype wire

// ### bus_receiver.sv
// Downstream receiver model seeing the driven bus.
// Assumes one enable per lane, high while driven; a released lane shows the inverse.
`timescale 1ns/100ps
`default_nettype none
module bus_receiver (
    input  wire logic        i_mclk,
    input  wire logic [17:0] i_y,
    input  wire logic [17:0] i_oe,
    output logic      [17:0] o_seen
);
    logic [17:0] last_ff;
    always_ff @(posedge i_mclk) begin
        last_ff <= o_seen;
    end
    assign o_seen = (i_oe & i_y) | (~i_oe & ~last_ff);
endmodule : bus_receiver
`default_nettype wire

// ### latchable_bus_driver_18.sv
// Top of the 18-lane latchable one-direction bus driver.
// Assumes all inputs synchronous to I_MCLK; I_CLK is sampled, not a clock.
`timescale 1ns/100ps
`default_nettype none
module latchable_bus_driver_18 #(
    parameter int LANES = bus_driver_pkg::LANES
) (
    input  wire logic             I_MCLK,
    input  wire logic             I_RESET_N,
    input  wire logic [LANES-1:0] I_A,
    input  wire logic             I_DRIVE_OFF,
    input  wire logic             I_PASS_THROUGH_N,
    input  wire logic             I_CLK,
    output logic      [LANES-1:0] O_Y,
    output logic      [LANES-1:0] O_Y_OE
);
    logic             clk_prev_ff;
    logic             capture;
    logic [LANES-1:0] stored;
    logic [LANES-1:0] lane_data;

    initial begin
        if (LANES < 1) begin
            $error("LANES must be at least one");
        end
    end

    // Lane clock history; starts high so release never fakes an edge
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            clk_prev_ff <= bus_driver_pkg::CLK_PREV_RST;
        end else begin
            clk_prev_ff <= I_CLK;
        end
    end

    // Rising lane clock while latching
    assign capture = I_PASS_THROUGH_N && I_CLK && !clk_prev_ff;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            bus_lane u_lane (
                .i_mclk           (I_MCLK),
                .i_data           (I_A[g]),
                .i_pass_through_n (I_PASS_THROUGH_N),
                .i_capture        (capture),
                .o_stored         (stored[g]),
                .o_data           (lane_data[g])
            );
        end
    endgenerate

    // Off forces every lane to zero, otherwise passes the word
    function automatic logic [LANES-1:0] drive_value(
        input logic             off,
        input logic [LANES-1:0] data
    );
        drive_value = off ? '0 : data;
    endfunction : drive_value

    assign O_Y    = drive_value(I_DRIVE_OFF, lane_data);
    assign O_Y_OE = drive_value(I_DRIVE_OFF, {LANES{1'b1}});

    // Pass-through rising while the lane clock already stands high
    sequence s_pt_rise_clk_high;
        $rose(I_PASS_THROUGH_N) && I_CLK && $past(I_CLK);
    endsequence

    // Latching with no capture at this sample
    sequence s_latched_idle;
        I_PASS_THROUGH_N && !capture;
    endsequence

    // Latching, driving, no capture, then still latching and driving
    sequence s_hold_two;
        (I_PASS_THROUGH_N && !capture && !I_DRIVE_OFF)
        ##1 (I_PASS_THROUGH_N && !I_DRIVE_OFF);
    endsequence

    // Pass-through rise with clock high, then clock still high
    sequence s_pt_rise_held;
        ($rose(I_PASS_THROUGH_N) && I_CLK && $past(I_CLK) && !I_DRIVE_OFF)
        ##1 (I_PASS_THROUGH_N && I_CLK && !I_DRIVE_OFF);
    endsequence

    // Capture, one quiet latched cycle, then driven
    sequence s_capture_kept;
        capture ##1 s_latched_idle ##1 (I_PASS_THROUGH_N && !I_DRIVE_OFF);
    endsequence

    // Lane clock held high across two samples while latching
    sequence s_clk_high_steady;
        I_PASS_THROUGH_N && I_CLK && $past(I_CLK);
    endsequence

    // Output enable and drive-off
    drive_off_z_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        I_DRIVE_OFF |-> (O_Y_OE == '0) && (O_Y == '0))
        else $error("Outputs driven while drive-off high");

    drive_on_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        !I_DRIVE_OFF |-> (O_Y_OE == {LANES{1'b1}}))
        else $error("Outputs not enabled while drive-off low");

    transp_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (!I_DRIVE_OFF && !I_PASS_THROUGH_N) |-> (O_Y == I_A))
        else $error("Transparent output does not follow input");

    transp_store_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        !I_PASS_THROUGH_N |=> (stored == $past(I_A)))
        else $error("Storage not tracking input while transparent");

    // First sample after release carries no lane clock history
    edge_capture_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        ($past(I_RESET_N) && I_PASS_THROUGH_N && $rose(I_CLK)) |=> (stored == $past(I_A)))
        else $error("Rising lane clock did not capture input");

    capture_show_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        capture ##1 (I_PASS_THROUGH_N && !I_DRIVE_OFF) |-> (O_Y == $past(I_A)))
        else $error("Captured value not presented");

    steady_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        s_latched_idle |=> (stored == $past(stored)))
        else $error("Stored value changed without capture");

    pt_rise_keep_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        s_pt_rise_clk_high |-> !capture && (stored == $past(I_A)))
        else $error("Level lost when latching with clock high");

    // Storage while outputs are off
    off_store_kept_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_DRIVE_OFF && I_PASS_THROUGH_N && !capture) |=> (stored == $past(stored)))
        else $error("Drive-off altered storage");

    off_capture_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_DRIVE_OFF && capture) |=> (stored == $past(I_A)))
        else $error("Capture lost while drive-off high");

    // Transparent path ignores the lane clock
    transp_clk_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (!I_DRIVE_OFF && !I_PASS_THROUGH_N && $rose(I_CLK)) |-> (O_Y == I_A))
        else $error("Lane clock disturbed transparent output");

    // Held output stays put
    hold_stable_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        s_hold_two |-> $stable(O_Y))
        else $error("Held output changed without capture");

    clk_high_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        s_clk_high_steady |-> !capture)
        else $error("Steady high lane clock captured");

    capture_keep_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        s_capture_kept |-> (O_Y == $past(I_A, 2)))
        else $error("Captured value not kept");

    pt_rise_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        s_pt_rise_held |-> $stable(O_Y))
        else $error("Output moved before next lane clock rise");

    // Lane clock history
    clk_hist_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        $past(I_RESET_N) |-> (clk_prev_ff == $past(I_CLK)))
        else $error("Lane clock history out of step");

    reset_hist_a: assert property (@(posedge I_MCLK)
        !I_RESET_N |=> (clk_prev_ff == bus_driver_pkg::CLK_PREV_RST))
        else $error("Lane clock history not reset");

    release_no_edge_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        $rose(I_RESET_N) |-> !capture)
        else $error("False capture right after reset");

    // Every lane obeys the shared controls on its own
    genvar c;
    generate
        for (c = 0; c < LANES; c++) begin : g_lane_chk
            lane_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
                (!I_DRIVE_OFF && !I_PASS_THROUGH_N) |-> (O_Y[c] == I_A[c]))
                else $error("Lane does not follow its input");

            lane_oe_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
                O_Y_OE[c] == !I_DRIVE_OFF)
                else $error("Lane enable differs from shared control");

            lane_store_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
                !I_PASS_THROUGH_N |=> (stored[c] == $past(I_A[c])))
                else $error("Lane storage not loaded while transparent");

            lane_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
                s_latched_idle |=> (stored[c] == $past(stored[c])))
                else $error("Lane storage changed without capture");
        end
    endgenerate
endmodule : latchable_bus_driver_18
`default_nettype wire

// ### latchable_bus_driver_18_test.sv
// Self-checking bench for the 18-lane latchable bus driver.
// Assumes bus_driver_pkg and bus_receiver are compiled first.
`timescale 1ns/100ps
`default_nettype none
module latchable_bus_driver_18_test;
    logic        mclk, reset_n, off, pn, lclk;
    logic [17:0] a, y, oe, seen;
    int          fails, tests_run, cycles;
    latchable_bus_driver_18 i_latchable_bus_driver_18 (.I_MCLK(mclk), .I_RESET_N(reset_n),
        .I_A(a), .I_DRIVE_OFF(off), .I_PASS_THROUGH_N(pn), .I_CLK(lclk), .O_Y(y), .O_Y_OE(oe));
    bus_receiver i_bus_receiver (.i_mclk(mclk), .i_y(y), .i_oe(oe), .o_seen(seen));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Drive after the edge; c is {drive off, pass-through_n, lane clock}
    task automatic step(input logic [17:0] na, input logic [2:0] c);
        @(posedge mclk);
        #1;
        a = na;
        {off, pn, lclk} = c;
        #1;
    endtask : step
    task automatic check(input logic [17:0] exp, input logic [17:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask : check
    task automatic t_pass();
        step(18'h2a5a5, 3'b000);
        check(18'h2a5a5, seen);
        check(18'h3ffff, oe);
        step(18'h15a5a, 3'b001);
        check(18'h15a5a, seen);
    endtask : t_pass
    task automatic t_capture();
        step(18'h3c3c3, 3'b010);
        step(18'h3c3c3, 3'b011);
        step(18'h00f0f, 3'b011);
        check(18'h3c3c3, seen);
        step(18'h0f0f0, 3'b010);
        check(18'h3c3c3, seen);
    endtask : t_capture
    task automatic t_rise_high();
        step(18'h11111, 3'b001);
        step(18'h22222, 3'b011);
        step(18'h33333, 3'b011);
        check(18'h11111, seen);
        step(18'h33333, 3'b010);
        step(18'h33333, 3'b011);
        step(18'h00000, 3'b011);
        check(18'h33333, seen);
    endtask : t_rise_high
    task automatic t_off();
        step(18'h05555, 3'b110);
        check(18'h00000, oe);
        check(18'h00000, y);
        step(18'h05555, 3'b111);
        step(18'h00000, 3'b111);
        check(18'h00000, oe);
        step(18'h00000, 3'b011);
        check(18'h05555, seen);
    endtask : t_off
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 200) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        {reset_n, off, pn, lclk, a, fails, tests_run, cycles} = '0;
        repeat (5) @(posedge mclk);
        #1 reset_n = 1'b1;
        t_pass();
        t_capture();
        t_rise_high();
        t_off();
        wrap_up();
    end
endmodule : latchable_bus_driver_18_test
`default_nettype wire
